// ### src/weather_alarm_regs.vh
// Constants for the weather alarm logic: action codes, defaults, timing.
// Assumes inclusion by bare name from the design files under src/.
`ifndef WEATHER_ALARM_REGS_VH
`define WEATHER_ALARM_REGS_VH

// Action codes, shared by activation and deactivation settings
`define ACT_NONE 3'h0
`define ACT_UP 3'h1
`define ACT_DOWN 3'h2
`define ACT_PERCENT 3'h3
`define ACT_STOP 3'h4
`define ACT_PREVIOUS 3'h5
`define ACT_LAST_CMD 3'h6

// Defaults and limits
`define DEF_WIND_COUNT 2'h0
`define DEF_ACTIVE_LEVEL 1'h1
`define DEF_PERCENT 7'h00
`define DEF_MONITOR_MIN 6'h00
`define MAX_MONITOR_MIN 6'h3C
`define MAX_PERCENT 7'h64
`define PERCENT_STEP 7'h05

// Timing: one minute of the 200 MHz clock
`define CLK_HZ 200000000
`define MINUTE_S 60
// Written out at 34 bits: the product of the two above overflows 32-bit math
`define MINUTE_CYCLES 34'h2CB417800

// Class ordering codes: H/M/L
`define ORD_WRI 3'h0
`define ORD_WIR 3'h1
`define ORD_IRW 3'h2
`define ORD_IWR 3'h3
`define ORD_RWI 3'h4
`define ORD_RIW 3'h5

`endif

// ### src/minute_tick.v
// Free running divider that produces one-cycle pulses once a minute.
// Assumes clk at the rate set in the constants header.
`timescale 1ns/1ps
`default_nettype none
`include "weather_alarm_regs.vh"

module minute_tick #(
  parameter [33:0] MINUTE_CYCLES = `MINUTE_CYCLES
) (
  input wire clk,
  input wire rst,
  output reg tick
);

  reg [33:0] count_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Counter wraps after one minute of cycles
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      count_reg <= 34'h000000000;
      tick <= 1'b0;
    end else if (count_reg >= MINUTE_CYCLES - 34'h000000001) begin
      count_reg <= 34'h000000000;
      tick <= 1'b1;
    end else begin
      count_reg <= count_reg + 34'h000000001;
      tick <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// ### src/alarm_input.v
// One alarm input: polarity, edge detection and sensor watchdog.
// Assumes objects arrive as one-cycle strobes with their value alongside.
`timescale 1ns/1ps
`default_nettype none
`include "weather_alarm_regs.vh"

module alarm_input (
  input wire clk,
  input wire rst,
  input wire enable,
  input wire clearAll,
  input wire minuteTick,
  input wire objStrobe,
  input wire objValue,
  input wire activeLevel,
  input wire [5:0] monitorMinutes,
  output reg active,
  output reg rise,
  output reg fall
);

  reg [5:0] minutes_reg;
  reg objActive_reg;
  reg timeout_reg;
  wire monitorOn = (monitorMinutes != 6'h00);
  wire activeNext = enable & (objActive_reg | timeout_reg);

  ////////////////////////////////////////////////////////////////////////////
  // Received level and watchdog; any object restarts the minute count
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      objActive_reg <= 1'b0;
      timeout_reg <= 1'b0;
      minutes_reg <= 6'h00;
    end else if (clearAll || !enable) begin
      objActive_reg <= 1'b0;
      timeout_reg <= 1'b0;
      minutes_reg <= 6'h00;
    end else if (objStrobe) begin
      objActive_reg <= (objValue == activeLevel);
      timeout_reg <= 1'b0;
      minutes_reg <= 6'h00;
    end else if (monitorOn && minuteTick && !timeout_reg) begin
      // Tick phase is free running, so the first minute may be short
      if (minutes_reg + 6'h01 >= monitorMinutes)
        timeout_reg <= 1'b1;
      minutes_reg <= minutes_reg + 6'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Edge pulses toward the arbiter; a bus recovery drops the level silently
  // so that no deactivation action follows the clear
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      active <= 1'b0;
      rise <= 1'b0;
      fall <= 1'b0;
    end else if (clearAll) begin
      active <= 1'b0;
      rise <= 1'b0;
      fall <= 1'b0;
    end else begin
      active <= activeNext;
      rise <= activeNext & ~active;
      fall <= ~activeNext & active;
    end
  end

endmodule
`default_nettype wire

// ### src/shutter_weather_alarm_logic.v
// Weather alarm handler for one shutter channel: three wind, one rain input.
// Assumes configuration is static between alarms and ice alarm state comes
// from outside as a level.
`timescale 1ns/1ps
`default_nettype none
`include "weather_alarm_regs.vh"

// Function
// - Zero to three wind inputs enabled per channel, default zero.
// - Each wind input active when value equals its level, default one.
// - Wind activation runs its action: none, up, down, percent or stop.
// - Wind percent targets 0..100 in fives; louvre only for venetian.
// - Wind monitoring period 0..60 minutes; zero disables it.
// - Silent monitored wind sensor triggers its activation action.
// - Wind deactivation runs its action, including previous and last command.
// - Wind three ranks highest, wind one lowest.
// - Deactivation action only when no other wind or lower alarm active.
// - Optional rain input, disabled by default.
// - Rain active when value equals its level, default one.
// - Rain activation runs its action with shade and louvre targets.
// - Rain monitoring 0..60 minutes; silence triggers activation action.
// - Rain deactivation runs its action, including previous and last command.
// - Rain deactivation percent targets 0..100 in fives, louvre venetian only.
// - Six class orderings; after deactivation follow highest still active.
// - Bus voltage recovery clears every alarm state; the external ice level is only masked for that cycle.
module shutter_weather_alarm_logic #(
  parameter [33:0] MINUTE_CYCLES = `MINUTE_CYCLES
) (
  input wire clk,
  input wire rst,
  input wire busRecovered,
  input wire venetianMode,
  input wire [1:0] windCount,
  input wire [2:0] gustAlertStrobe,
  input wire [2:0] gustAlertInput,
  input wire [2:0] windActiveLevel,
  input wire [8:0] windOnAction,
  input wire [8:0] windOffAction,
  input wire [17:0] windMonitorMinutes,
  input wire [20:0] windOnShade,
  input wire [20:0] windOnLouvre,
  input wire [20:0] windOffShade,
  input wire [20:0] windOffLouvre,
  input wire rainEnable,
  input wire precipitationAlertStrobe,
  input wire precipitationAlertInput,
  input wire rainActiveLevel,
  input wire [2:0] rainOnAction,
  input wire [2:0] rainOffAction,
  input wire [5:0] rainMonitorMinutes,
  input wire [6:0] rainOnShade,
  input wire [6:0] rainOnLouvre,
  input wire [6:0] rainOffShade,
  input wire [6:0] rainOffLouvre,
  input wire iceActive,
  input wire [2:0] iceOnAction,
  input wire [6:0] iceOnShade,
  input wire [6:0] iceOnLouvre,
  input wire [2:0] classOrder,
  input wire [6:0] currentShade,
  input wire [6:0] currentLouvre,
  output reg cmdValid,
  output reg [2:0] cmdAction,
  output reg [6:0] cmdShade,
  output reg [6:0] cmdLouvre,
  output reg anyAlarm,
  output reg [2:0] windAlarmActive,
  output reg rainAlarmActive,
  output reg [6:0] savedShade,
  output reg [6:0] savedLouvre
);

  localparam CLS_WIND = 2'h0;
  localparam CLS_RAIN = 2'h1;
  localparam CLS_ICE = 2'h2;
  localparam CLS_NONE = 2'h3;

  wire tick;
  wire [2:0] wActive;
  wire [2:0] wRise;
  wire [2:0] wFall;
  wire rActive;
  wire rRise;
  wire rFall;
  reg iceActive_reg;
  reg icePrev_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Clamp a percentage to 0..100 on a 5 step; louvre ignored unless venetian
  function [6:0] snapPercent;
    input [6:0] p;
    reg [6:0] c;
    begin
      c = (p > `MAX_PERCENT) ? `MAX_PERCENT : p;
      snapPercent = c - (c % `PERCENT_STEP);
    end
  endfunction

  function [6:0] louvreOf;
    input [6:0] p;
    input ven;
    begin
      louvreOf = ven ? snapPercent(p) : `DEF_PERCENT;
    end
  endfunction

  // Rank of a class under the selected ordering: 2 high, 1 medium, 0 low
  function [1:0] rankOf;
    input [1:0] cls;
    input [2:0] ord;
    reg [5:0] r;
    begin
      case (ord)
        `ORD_WIR: r = {2'h2, 2'h0, 2'h1};
        `ORD_IRW: r = {2'h0, 2'h1, 2'h2};
        `ORD_IWR: r = {2'h1, 2'h0, 2'h2};
        `ORD_RWI: r = {2'h1, 2'h2, 2'h0};
        `ORD_RIW: r = {2'h0, 2'h2, 2'h1};
        default: r = {2'h2, 2'h1, 2'h0}; // Default wind, rain, ice
      endcase
      case (cls)
        CLS_WIND: rankOf = r[5:4];
        CLS_RAIN: rankOf = r[3:2];
        default: rankOf = r[1:0];
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  minute_tick #(
    .MINUTE_CYCLES(MINUTE_CYCLES)
  ) u_tick (
    .clk(clk),
    .rst(rst),
    .tick(tick)
  );

  // Wind inputs beyond the configured count stay disabled
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_wind
      alarm_input u_wind (
        .clk(clk),
        .rst(rst),
        .enable(windCount > gi),
        .clearAll(busRecovered),
        .minuteTick(tick),
        .objStrobe(gustAlertStrobe[gi]),
        .objValue(gustAlertInput[gi]),
        .activeLevel(windActiveLevel[gi]),
        .monitorMinutes(windMonitorMinutes[gi*6 +: 6]),
        .active(wActive[gi]),
        .rise(wRise[gi]),
        .fall(wFall[gi])
      );
    end
  endgenerate

  alarm_input u_rain (
    .clk(clk),
    .rst(rst),
    .enable(rainEnable),
    .clearAll(busRecovered),
    .minuteTick(tick),
    .objStrobe(precipitationAlertStrobe),
    .objValue(precipitationAlertInput),
    .activeLevel(rainActiveLevel),
    .monitorMinutes(rainMonitorMinutes),
    .active(rActive),
    .rise(rRise),
    .fall(rFall)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Highest wind index active, and whether any wind input is active
  reg [1:0] topWind;
  reg windAny;
  always @* begin
    windAny = |wActive;
    topWind = wActive[2] ? 2'h2 : (wActive[1] ? 2'h1 : 2'h0);
  end

  // Highest class still active under the configured ordering
  reg [1:0] topClass;
  reg [1:0] topRank;
  always @* begin
    topClass = CLS_NONE;
    topRank = 2'h0;
    if (windAny) begin
      topClass = CLS_WIND;
      topRank = rankOf(CLS_WIND, classOrder);
    end
    if (rActive && (topClass == CLS_NONE || rankOf(CLS_RAIN, classOrder) > topRank)) begin
      topClass = CLS_RAIN;
      topRank = rankOf(CLS_RAIN, classOrder);
    end
    if (iceActive_reg &&
        (topClass == CLS_NONE || rankOf(CLS_ICE, classOrder) > topRank)) begin
      topClass = CLS_ICE;
      topRank = rankOf(CLS_ICE, classOrder);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command selection; any activation, or a deactivation that leaves an alarm
  // active, issues the highest active alarm's activation command
  reg issue;
  reg [2:0] actNext;
  reg [6:0] shadeNext;
  reg [6:0] louvreNext;
  reg [1:0] fallWind;
  reg anyRise;
  reg anyFall;
  reg anyNow;
  always @* begin
    issue = 1'b0;
    actNext = `ACT_NONE;
    shadeNext = `DEF_PERCENT;
    louvreNext = `DEF_PERCENT;
    // Ice edges taken on the registered level so they line up with anyNow
    anyRise = (|wRise) | rRise | (iceActive_reg & ~icePrev_reg);
    anyFall = (|wFall) | rFall | (~iceActive_reg & icePrev_reg);
    anyNow = windAny | rActive | iceActive_reg;
    fallWind = wFall[2] ? 2'h2 : (wFall[1] ? 2'h1 : 2'h0);
    if ((anyRise || anyFall) && anyNow) begin
      issue = 1'b1;
      case (topClass)
        CLS_WIND: begin
          actNext = windOnAction[topWind*3 +: 3];
          shadeNext = snapPercent(windOnShade[topWind*7 +: 7]);
          louvreNext = louvreOf(windOnLouvre[topWind*7 +: 7], venetianMode);
        end
        CLS_RAIN: begin
          actNext = rainOnAction;
          shadeNext = snapPercent(rainOnShade);
          louvreNext = louvreOf(rainOnLouvre, venetianMode);
        end
        CLS_ICE: begin
          actNext = iceOnAction;
          shadeNext = snapPercent(iceOnShade);
          louvreNext = louvreOf(iceOnLouvre, venetianMode);
        end
        default: begin
          issue = 1'b0;
        end
      endcase
    end else if (anyFall && !anyNow) begin
      // Last alarm gone: its own deactivation action runs
      issue = 1'b1;
      if (|wFall) begin
        actNext = windOffAction[fallWind*3 +: 3];
        shadeNext = snapPercent(windOffShade[fallWind*7 +: 7]);
        louvreNext = louvreOf(windOffLouvre[fallWind*7 +: 7], venetianMode);
      end else if (rFall) begin
        actNext = rainOffAction;
        shadeNext = snapPercent(rainOffShade);
        louvreNext = louvreOf(rainOffLouvre, venetianMode);
      end else begin
        issue = 1'b0; // Ice deactivation handled outside
      end
      if (actNext == `ACT_PREVIOUS) begin
        shadeNext = savedShade;
        louvreNext = venetianMode ? savedLouvre : `DEF_PERCENT;
      end
    end
    if (issue && actNext == `ACT_NONE)
      issue = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output registers and position snapshot at the first alarm
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      iceActive_reg <= 1'b0;
      icePrev_reg <= 1'b0;
      cmdValid <= 1'b0;
      cmdAction <= `ACT_NONE;
      cmdShade <= `DEF_PERCENT;
      cmdLouvre <= `DEF_PERCENT;
      anyAlarm <= 1'b0;
      windAlarmActive <= 3'h0;
      rainAlarmActive <= 1'b0;
      savedShade <= `DEF_PERCENT;
      savedLouvre <= `DEF_PERCENT;
    end else begin
      iceActive_reg <= iceActive & ~busRecovered;
      icePrev_reg <= iceActive_reg & ~busRecovered;
      cmdValid <= issue & ~busRecovered;
      if (issue) begin
        cmdAction <= actNext;
        cmdShade <= shadeNext;
        cmdLouvre <= louvreNext;
      end
      anyAlarm <= anyNow;
      windAlarmActive <= wActive;
      rainAlarmActive <= rActive;
      // Idle is judged on the registered summary; anyNow already shows the new alarm
      if (anyRise && !anyAlarm) begin
        savedShade <= currentShade;
        savedLouvre <= currentLouvre;
      end
    end
  end

endmodule
`default_nettype wire

// ### testbench/shutter_weather_alarm_props.sv
// Concurrent checks on the top ports of the weather alarm block.
// Assumes the constants header is on the include path; bound below.
`timescale 1ns/1ps
`default_nettype none
`include "weather_alarm_regs.vh"
module shutter_weather_alarm_props #(
  parameter [33:0] MINUTE_CYCLES = 34'h1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic busRecovered,
  input wire logic venetianMode,
  input wire logic [1:0] windCount,
  input wire logic [2:0] gustAlertStrobe,
  input wire logic [2:0] gustAlertInput,
  input wire logic [2:0] windActiveLevel,
  input wire logic [8:0] windOnAction,
  input wire logic [8:0] windOffAction,
  input wire logic rainEnable,
  input wire logic iceActive,
  input wire logic [2:0] classOrder,
  input wire logic [6:0] currentShade,
  input wire logic [6:0] currentLouvre,
  input wire logic cmdValid,
  input wire logic [2:0] cmdAction,
  input wire logic [6:0] cmdShade,
  input wire logic [6:0] cmdLouvre,
  input wire logic anyAlarm,
  input wire logic [2:0] windAlarmActive,
  input wire logic rainAlarmActive,
  input wire logic [6:0] savedShade,
  input wire logic [6:0] savedLouvre
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  ////////////////////////////////////////////////////////////////////////////////
  // Fresh activation of wind input 1 from idle gives its command three edges later
  AST_WIND_ON: assert property (
    (gustAlertStrobe[0] && windCount != 2'h0 && gustAlertInput[0] == windActiveLevel[0]
     && windAlarmActive == 3'h0 && !anyAlarm && !busRecovered && !iceActive
     && classOrder == 3'h0 && windOnAction[2:0] != `ACT_NONE)
    |-> ##3 (cmdValid && cmdAction == windOnAction[2:0])) else $error("wind on command missing");
  AST_NO_NONE: assert property (cmdValid |-> cmdAction != `ACT_NONE)
    else $error("command issued with no action");
  AST_DISABLED_WIND: assert property ((windCount == 2'h0)[*4] |-> windAlarmActive == 3'h0)
    else $error("disabled wind input active");
  AST_RAIN_OFF: assert property ((!rainEnable)[*4] |-> !rainAlarmActive)
    else $error("disabled rain input active");
  AST_PERCENT_GRID: assert property (
    (cmdValid && cmdAction == `ACT_PERCENT) |-> (cmdShade <= `MAX_PERCENT && cmdShade % 5 == 0))
    else $error("percent target off grid");
  AST_LOUVRE_SHUTTER: assert property (
    (cmdValid && !venetianMode && $stable(venetianMode)) |-> cmdLouvre == 7'h00)
    else $error("louvre target outside venetian mode");
  // A lower wind alarm rising under wind 3 repeats the top command
  AST_WIND_RANK: assert property (
    ($rose(windAlarmActive[0]) && windAlarmActive[2] && $past(windAlarmActive[2])
     && classOrder == 3'h0 && windOnAction[8:6] != `ACT_NONE)
    |-> (cmdValid && cmdAction == windOnAction[8:6])) else $error("top wind command missing");
  AST_WIND_OFF: assert property (
    ($fell(windAlarmActive[0]) && windAlarmActive[2:1] == 2'h0 && !rainAlarmActive && !iceActive
     && !$past(busRecovered) && !$past(busRecovered, 2) && windOffAction[2:0] != `ACT_NONE)
    |-> (cmdValid && cmdAction == windOffAction[2:0])) else $error("wind off command missing");
  // Deactivating wind 3 with wind 2 still active must follow wind 2, not its own off action
  AST_OFF_HELD: assert property (
    ($fell(windAlarmActive[2]) && windAlarmActive[1] && classOrder == 3'h0)
    |-> (cmdValid && cmdAction == windOnAction[5:3])) else $error("remaining alarm not followed");
  AST_ANY: assert property ((windAlarmActive != 3'h0 || rainAlarmActive) |-> anyAlarm)
    else $error("alarm summary low");
  AST_BUS_CLEAR: assert property (
    busRecovered |-> ##2 (windAlarmActive == 3'h0 && !rainAlarmActive))
    else $error("alarm state kept after bus recovery");
  AST_SNAPSHOT: assert property (
    ($rose(anyAlarm) && $past(currentShade, 2) == currentShade
     && $past(currentLouvre, 2) == currentLouvre)
    |-> (savedShade == currentShade && savedLouvre == currentLouvre))
    else $error("position snapshot wrong");

  // Main scenarios reached
  COV_ALL_WIND: cover property (windAlarmActive == 3'h7);
  COV_RAIN: cover property ($rose(rainAlarmActive));
  COV_BUS: cover property (busRecovered && anyAlarm);
endmodule

bind shutter_weather_alarm_logic shutter_weather_alarm_props #(.MINUTE_CYCLES(MINUTE_CYCLES)) props (
  .clk(clk), .rst(rst), .busRecovered(busRecovered), .venetianMode(venetianMode),
  .windCount(windCount), .gustAlertStrobe(gustAlertStrobe), .gustAlertInput(gustAlertInput),
  .windActiveLevel(windActiveLevel), .windOnAction(windOnAction),
  .windOffAction(windOffAction), .rainEnable(rainEnable), .iceActive(iceActive),
  .classOrder(classOrder), .currentShade(currentShade), .currentLouvre(currentLouvre),
  .cmdValid(cmdValid), .cmdAction(cmdAction), .cmdShade(cmdShade), .cmdLouvre(cmdLouvre),
  .anyAlarm(anyAlarm), .windAlarmActive(windAlarmActive), .rainAlarmActive(rainAlarmActive),
  .savedShade(savedShade), .savedLouvre(savedLouvre)
);
`default_nettype wire

// ### testbench/weather_sensor_model.sv
// Weather sensors on the bus: wind 1..3 in bits 2:0, rain in bit 3.
// Assumes requests are raised just after a rising edge for one cycle.
`timescale 1ns/1ps
`default_nettype none
module weather_sensor_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] sendReq,
  input wire logic [3:0] sendVal,
  output logic [3:0] objStrobe,
  output logic [3:0] objValue
);
  // One-cycle object strobe; between objects the value toggles so stale data never looks valid
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      objStrobe <= 4'h0;
      objValue <= 4'h0;
    end else begin
      objStrobe <= sendReq;
      objValue <= (sendVal & sendReq) | (~objValue & ~sendReq);
    end
  end
endmodule
`default_nettype wire

// ### testbench/shutter_weather_alarm_logic_bench.sv
// Self-checking bench for the weather alarm block with a sensor model.
// Assumes the constants header on the include path; minute shortened to 20 cycles.
`timescale 1ns/1ps
`default_nettype none
`include "weather_alarm_regs.vh"
module shutter_weather_alarm_logic_bench;
  logic clk, rst, busRecovered, venetianMode, rainEnable, rainActiveLevel, iceActive;
  logic [1:0] windCount;
  logic [2:0] windActiveLevel, rainOnAction, rainOffAction, classOrder;
  logic [8:0] windOnAction, windOffAction;
  logic [17:0] windMonitorMinutes;
  logic [5:0] rainMonitorMinutes;
  logic [20:0] windOnShade, windOnLouvre, windOffShade, windOffLouvre;
  logic [6:0] rainOnShade, rainOnLouvre, rainOffShade, rainOffLouvre, currentShade, currentLouvre;
  logic [3:0] sendReq, sendVal;
  wire [3:0] objStrobe, objValue;
  wire cmdValid, anyAlarm, rainAlarmActive;
  wire [2:0] cmdAction, windAlarmActive;
  wire [6:0] cmdShade, cmdLouvre, savedShade, savedLouvre;
  int num_errors = 0;
  int compares = 0;

  weather_sensor_model sensors (.clk(clk), .rst(rst), .sendReq(sendReq), .sendVal(sendVal),
    .objStrobe(objStrobe), .objValue(objValue));

  shutter_weather_alarm_logic #(.MINUTE_CYCLES(34'h14)) dut (
    .clk(clk), .rst(rst), .busRecovered(busRecovered), .venetianMode(venetianMode),
    .windCount(windCount), .gustAlertStrobe(objStrobe[2:0]), .gustAlertInput(objValue[2:0]),
    .windActiveLevel(windActiveLevel), .windOnAction(windOnAction),
    .windOffAction(windOffAction), .windMonitorMinutes(windMonitorMinutes),
    .windOnShade(windOnShade), .windOnLouvre(windOnLouvre), .windOffShade(windOffShade),
    .windOffLouvre(windOffLouvre), .rainEnable(rainEnable),
    .precipitationAlertStrobe(objStrobe[3]), .precipitationAlertInput(objValue[3]),
    .rainActiveLevel(rainActiveLevel), .rainOnAction(rainOnAction),
    .rainOffAction(rainOffAction), .rainMonitorMinutes(rainMonitorMinutes),
    .rainOnShade(rainOnShade), .rainOnLouvre(rainOnLouvre), .rainOffShade(rainOffShade),
    .rainOffLouvre(rainOffLouvre), .iceActive(iceActive), .iceOnAction(`ACT_STOP),
    .iceOnShade(7'h00), .iceOnLouvre(7'h00), .classOrder(classOrder), .currentShade(currentShade),
    .currentLouvre(currentLouvre), .cmdValid(cmdValid), .cmdAction(cmdAction),
    .cmdShade(cmdShade), .cmdLouvre(cmdLouvre), .anyAlarm(anyAlarm),
    .windAlarmActive(windAlarmActive), .rainAlarmActive(rainAlarmActive),
    .savedShade(savedShade), .savedLouvre(savedLouvre));

  ////////////////////////////////////////////////////////////////////////////////
  task stop_test;
    if (num_errors == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task chk(input string n, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask

  // One object from sensor idx; the model strobes it on the next cycle
  task sendObj(input int idx, input logic v);
    sendReq[idx] = 1'b1;
    sendVal[idx] = v;
    @(posedge clk);
    #1;
    sendReq = 4'h0;
  endtask

  // Bounded wait for a command; 7'h7F skips a position compare
  task expectCmd(input logic [2:0] a, input logic [6:0] s, input logic [6:0] l);
    int i;
    i = 0;
    while (cmdValid !== 1'b1 && i < 100) begin
      @(posedge clk);
      #1;
      i++;
    end
    chk("cmdValid", 8'h01, cmdValid);
    chk("cmdAction", a, cmdAction);
    if (s !== 7'h7F) chk("cmdShade", s, cmdShade);
    if (l !== 7'h7F) chk("cmdLouvre", l, cmdLouvre);
    @(posedge clk);
    #1;
  endtask

  task noCmd(input int n);
    repeat (n) begin
      @(posedge clk);
      #1;
      chk("cmdValid", 8'h00, cmdValid);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task testDisabled;
    chk("anyAlarm", 8'h00, anyAlarm);
    sendObj(0, 1'b1);
    noCmd(6);
    sendObj(3, 1'b1);
    noCmd(6);
    chk("anyAlarm", 8'h00, anyAlarm);
  endtask

  task testSingle;
    windCount = 2'h1;
    sendObj(0, 1'b1);
    expectCmd(`ACT_UP, 7'h7F, 7'h7F);
    chk("savedShade", 8'h28, savedShade);
    chk("savedLouvre", 8'h0A, savedLouvre);
    chk("anyAlarm", 8'h01, anyAlarm);
    sendObj(0, 1'b1);
    noCmd(6);
    sendObj(0, 1'b0);
    expectCmd(`ACT_PREVIOUS, 7'h7F, 7'h7F);
  endtask

  // Wind 2 is active low; stack all three and unwind them
  task testPriority;
    windCount = 2'h3;
    sendObj(1, 1'b1);
    noCmd(6);
    sendObj(1, 1'b0);
    expectCmd(`ACT_PERCENT, 7'h23, 7'h32);
    sendObj(2, 1'b1);
    expectCmd(`ACT_DOWN, 7'h7F, 7'h7F);
    sendObj(0, 1'b1);
    expectCmd(`ACT_DOWN, 7'h7F, 7'h7F);
    sendObj(2, 1'b0);
    expectCmd(`ACT_PERCENT, 7'h23, 7'h32);
    sendObj(1, 1'b1);
    expectCmd(`ACT_UP, 7'h7F, 7'h7F);
    sendObj(0, 1'b0);
    expectCmd(`ACT_PREVIOUS, 7'h7F, 7'h7F);
  endtask

  // Shutter mode, so louvre targets must read zero
  task testRain;
    venetianMode = 1'b0;
    rainEnable = 1'b1;
    sendObj(3, 1'b1);
    expectCmd(`ACT_STOP, 7'h7F, 7'h7F);
    sendObj(3, 1'b0);
    expectCmd(`ACT_PERCENT, 7'h64, 7'h00);
    sendObj(3, 1'b0);
    rainMonitorMinutes = 6'h01;
    expectCmd(`ACT_STOP, 7'h7F, 7'h7F);
    rainMonitorMinutes = 6'h00;
    sendObj(3, 1'b0);
    expectCmd(`ACT_PERCENT, 7'h64, 7'h00);
    venetianMode = 1'b1;
  endtask

  // Objects every 16 cycles keep a two-minute watchdog quiet; silence trips it
  task testWatchdog;
    windCount = 2'h1;
    sendObj(0, 1'b0);
    noCmd(1);
    windMonitorMinutes = 18'h00002;
    repeat (4) begin
      sendObj(0, 1'b0);
      noCmd(15);
    end
    expectCmd(`ACT_UP, 7'h7F, 7'h7F);
    windMonitorMinutes = 18'h00000;
    sendObj(0, 1'b0);
    expectCmd(`ACT_PREVIOUS, 7'h7F, 7'h7F);
  endtask

  task testBusRecovery;
    sendObj(0, 1'b1);
    expectCmd(`ACT_UP, 7'h7F, 7'h7F);
    busRecovered = 1'b1;
    @(posedge clk);
    #1;
    busRecovered = 1'b0;
    noCmd(4);
    chk("windAlarmActive", 8'h00, windAlarmActive);
    sendObj(0, 1'b1);
    expectCmd(`ACT_UP, 7'h7F, 7'h7F);
  endtask

  // Wind 1 still active: ice ranked above wind takes over, then ranked below it
  task testIce;
    classOrder = `ORD_IWR;
    iceActive = 1'b1;
    expectCmd(`ACT_STOP, 7'h7F, 7'h7F);
    iceActive = 1'b0;
    expectCmd(`ACT_UP, 7'h7F, 7'h7F);
    classOrder = `ORD_WRI;
    iceActive = 1'b1;
    expectCmd(`ACT_UP, 7'h7F, 7'h7F);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  initial begin
    #20000;
    num_errors++;
    stop_test();
  end

  // Channel setup: wind on actions up/percent/down, off previous/stop/last command
  initial begin
    rst = 1'b1;
    busRecovered = 1'b0;
    venetianMode = 1'b1;
    windCount = 2'h0;
    windActiveLevel = 3'h5;
    windOnAction = {`ACT_DOWN, `ACT_PERCENT, `ACT_UP};
    windOffAction = {`ACT_LAST_CMD, `ACT_STOP, `ACT_PREVIOUS};
    windMonitorMinutes = 18'h00000;
    windOnShade = 21'h01180; // Input 2 at bits 13:7: shade 35
    windOnLouvre = 21'h01900; // Input 2 louvre 50
    windOffShade = 21'h00000;
    windOffLouvre = 21'h00000;
    rainEnable = 1'b0;
    rainActiveLevel = 1'b1;
    rainOnAction = `ACT_STOP;
    rainOffAction = `ACT_PERCENT;
    rainMonitorMinutes = 6'h00;
    rainOnShade = 7'h00;
    rainOnLouvre = 7'h00;
    rainOffShade = 7'h64;
    rainOffLouvre = 7'h05;
    iceActive = 1'b0;
    classOrder = `ORD_WRI;
    currentShade = 7'h28;
    currentLouvre = 7'h0A;
    sendReq = 4'h0;
    sendVal = 4'h0;
    repeat (5) @(posedge clk);
    #1;
    rst = 1'b0;
    testDisabled();
    testSingle();
    testPriority();
    testRain();
    testWatchdog();
    testBusRecovery();
    testIce();
    stop_test();
  end
endmodule
`default_nettype wire
